//--- reg_flags_cfg.svh
// Purpose: field positions, masks, reset values and command codes of the fault flags
// Assumes: included by the package and by the flag bank module
// Notes: command codes are read opcodes delivered by the serial command decoder
`ifndef REG_FLAGS_CFG_SVH
`define REG_FLAGS_CFG_SVH

// read command codes, one per status register
`define CMD_READ_PRE_REG_FAULT 8'h21
`define CMD_READ_PRE_REG_THERMAL 8'h22
`define CMD_READ_LV_REG_FAULT 8'h23

// pre-regulator fault register fields
`define PRE_FAULT_EXTREME_OV_BIT 5
`define PRE_FAULT_GROUND_LOSS_BIT 4
`define PRE_FAULT_OV_PROTECT_BIT 3
`define PRE_FAULT_SINK_LIMIT_BIT 2
`define PRE_FAULT_OVERLOAD_BIT 1
`define PRE_FAULT_SHORT_GND_BIT 0
`define PRE_FAULT_MASK 8'h3F

// pre-regulator thermal register fields
`define PRE_THERM_SHUTDOWN_BIT 1
`define PRE_THERM_WARNING_BIT 0
`define PRE_THERM_MASK 8'h03

// low-voltage regulator fault register fields
`define LV_FAULT_GROUND_LOSS_BIT 4
`define LV_FAULT_OV_PROTECT_BIT 3
`define LV_FAULT_SINK_LIMIT_BIT 2
`define LV_FAULT_OVERLOAD_BIT 1
`define LV_FAULT_SHORT_GND_BIT 0
`define LV_FAULT_MASK 8'h1F

// reset values
`define FLAG_RESET_VALUE 8'h00
`define READ_DATA_RESET_VALUE 8'h00

`endif

//--- reg_flags_pkg.sv
// Purpose: types shared by the fault flag bank
// Assumes: reg_flags_cfg.svh supplies the command codes
// Notes: none
`include "reg_flags_cfg.svh"

package reg_flags_pkg;

    // the three read commands the bank answers
    typedef enum logic [7:0] {
        READ_PRE_REG_FAULT_CMD = `CMD_READ_PRE_REG_FAULT,
        READ_PRE_REG_THERMAL_CMD = `CMD_READ_PRE_REG_THERMAL,
        READ_LV_REG_FAULT_CMD = `CMD_READ_LV_REG_FAULT
    } cmd_code_type;

    // whole state of the bank
    typedef struct packed {
        logic [7:0] pre_fault;
        logic [7:0] pre_therm;
        logic [7:0] lv_fault;
        logic [7:0] rd_data;
        logic rd_valid;
        logic cmd_err;
        logic fault_pending;
    } state_type;

endpackage

//--- regulator_fault_status_flags.sv
// Purpose: read-to-clear fault and thermal flags of the pre- and low-voltage regulators
// Assumes: fault conditions are synchronous levels; commands come decoded from the serial port
// Notes: read data is the latched value before the read clears it
`timescale 1ns/1ps
`include "reg_flags_cfg.svh"

module regulator_fault_status_flags (
    // clock and power-on reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // pre-regulator fault conditions
    input wire logic pre_reg_extreme_ov_cond,
    input wire logic pre_reg_ground_loss_cond,
    input wire logic pre_reg_ov_protect_cond,
    input wire logic pre_reg_sink_limit_cond,
    input wire logic pre_reg_overload_cond,
    input wire logic pre_reg_short_gnd_cond,
    // pre-regulator thermal conditions
    input wire logic pre_reg_thermal_shutdown_cond,
    input wire logic pre_reg_thermal_warning_cond,
    // low-voltage regulator fault conditions
    input wire logic lv_reg_ground_loss_cond,
    input wire logic lv_reg_ov_protect_cond,
    input wire logic lv_reg_sink_limit_cond,
    input wire logic lv_reg_overload_cond,
    input wire logic lv_reg_short_gnd_cond,
    // decoded command from the serial port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    // read answer
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic cmd_err,
    // live view of the flag registers
    output logic [7:0] pre_reg_fault_status,
    output logic [7:0] pre_reg_thermal_status,
    output logic [7:0] lv_reg_fault_status,
    output logic fault_pending
);

    reg_flags_pkg::state_type st_r;
    reg_flags_pkg::state_type st_nxt;
    logic [7:0] pre_fault_cond;
    logic [7:0] pre_therm_cond;
    logic [7:0] lv_fault_cond;
    logic rd_pre_fault;
    logic rd_pre_therm;
    logic rd_lv_fault;
    logic rd_any;

    // pack pre-regulator fault conditions into register layout
    always_comb begin
        pre_fault_cond = 8'h00;
        pre_fault_cond[`PRE_FAULT_EXTREME_OV_BIT] = pre_reg_extreme_ov_cond;
        pre_fault_cond[`PRE_FAULT_GROUND_LOSS_BIT] = pre_reg_ground_loss_cond;
        pre_fault_cond[`PRE_FAULT_OV_PROTECT_BIT] = pre_reg_ov_protect_cond;
        pre_fault_cond[`PRE_FAULT_SINK_LIMIT_BIT] = pre_reg_sink_limit_cond;
        pre_fault_cond[`PRE_FAULT_OVERLOAD_BIT] = pre_reg_overload_cond;
        pre_fault_cond[`PRE_FAULT_SHORT_GND_BIT] = pre_reg_short_gnd_cond;
    end

    // pack thermal conditions; reserved bits stay zero
    always_comb begin
        pre_therm_cond = 8'h00;
        pre_therm_cond[`PRE_THERM_SHUTDOWN_BIT] = pre_reg_thermal_shutdown_cond;
        pre_therm_cond[`PRE_THERM_WARNING_BIT] = pre_reg_thermal_warning_cond;
    end

    // pack low-voltage regulator conditions; bits 7-5 stay zero
    always_comb begin
        lv_fault_cond = 8'h00;
        lv_fault_cond[`LV_FAULT_GROUND_LOSS_BIT] = lv_reg_ground_loss_cond;
        lv_fault_cond[`LV_FAULT_OV_PROTECT_BIT] = lv_reg_ov_protect_cond;
        lv_fault_cond[`LV_FAULT_SINK_LIMIT_BIT] = lv_reg_sink_limit_cond;
        lv_fault_cond[`LV_FAULT_OVERLOAD_BIT] = lv_reg_overload_cond;
        lv_fault_cond[`LV_FAULT_SHORT_GND_BIT] = lv_reg_short_gnd_cond;
    end

    // command decode; a write is never a read, whatever its code
    always_comb begin
        rd_pre_fault = cmd_valid && !cmd_write
            && (cmd_code == 8'(reg_flags_pkg::READ_PRE_REG_FAULT_CMD));
        rd_pre_therm = cmd_valid && !cmd_write
            && (cmd_code == 8'(reg_flags_pkg::READ_PRE_REG_THERMAL_CMD));
        rd_lv_fault = cmd_valid && !cmd_write
            && (cmd_code == 8'(reg_flags_pkg::READ_LV_REG_FAULT_CMD));
        rd_any = rd_pre_fault || rd_pre_therm || rd_lv_fault;
    end

    // next state: set beats clear, so a fault during its own read is kept
    always_comb begin
        st_nxt = st_r;
        // latch new faults; a read drops only flags whose condition is gone
        st_nxt.pre_fault = ((st_r.pre_fault & ~({8{rd_pre_fault}} & ~pre_fault_cond))
            | pre_fault_cond) & `PRE_FAULT_MASK;
        st_nxt.pre_therm = ((st_r.pre_therm & ~({8{rd_pre_therm}} & ~pre_therm_cond))
            | pre_therm_cond) & `PRE_THERM_MASK;
        st_nxt.lv_fault = ((st_r.lv_fault & ~({8{rd_lv_fault}} & ~lv_fault_cond))
            | lv_fault_cond) & `LV_FAULT_MASK;
        // answer shows the latched value, so a transient fault is never missed
        st_nxt.rd_valid = rd_any;
        st_nxt.rd_data = `READ_DATA_RESET_VALUE;
        if (rd_pre_fault) begin
            st_nxt.rd_data = st_r.pre_fault;
        end else if (rd_pre_therm) begin
            st_nxt.rd_data = st_r.pre_therm;
        end else if (rd_lv_fault) begin
            st_nxt.rd_data = st_r.lv_fault;
        end
        // writes and unknown codes are refused and change no flag
        st_nxt.cmd_err = cmd_valid && !rd_any;
        st_nxt.fault_pending = |{st_nxt.pre_fault, st_nxt.pre_therm, st_nxt.lv_fault};
    end

    // single state register; sys_rst stands for the power-on reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r.pre_fault <= `FLAG_RESET_VALUE;
            st_r.pre_therm <= `FLAG_RESET_VALUE;
            st_r.lv_fault <= `FLAG_RESET_VALUE;
            st_r.rd_data <= `READ_DATA_RESET_VALUE;
            st_r.rd_valid <= 1'b0;
            st_r.cmd_err <= 1'b0;
            st_r.fault_pending <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign rd_data = st_r.rd_data;
    assign rd_valid = st_r.rd_valid;
    assign cmd_err = st_r.cmd_err;
    assign pre_reg_fault_status = st_r.pre_fault;
    assign pre_reg_thermal_status = st_r.pre_therm;
    assign lv_reg_fault_status = st_r.lv_fault;
    assign fault_pending = st_r.fault_pending;

    // checks on the flag behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // a present fault is latched one edge later
    a_fault_latches: assert property (
        (pre_fault_cond != 8'h00)
        |=> ((pre_reg_fault_status & $past(pre_fault_cond)) == $past(pre_fault_cond)))
    else $error("pre-regulator fault not latched");

    // without a read a set flag never falls
    a_flag_holds: assert property (
        !rd_lv_fault |=> ((lv_reg_fault_status & $past(lv_reg_fault_status))
            == $past(lv_reg_fault_status)))
    else $error("low-voltage flag fell without a read");

    // a read with no condition left clears the register at the next edge
    a_read_clears: assert property (
        (rd_pre_therm && (pre_therm_cond == 8'h00))
        ##1 (pre_therm_cond == 8'h00) |-> (pre_reg_thermal_status == 8'h00))
    else $error("thermal flags survived a read with no condition");

    // a condition still present during its read keeps the flag
    a_read_keeps: assert property (
        (rd_pre_fault && (pre_fault_cond != 8'h00))
        |=> ((pre_reg_fault_status & $past(pre_fault_cond)) == $past(pre_fault_cond))
            && rd_valid && (rd_data == $past(pre_reg_fault_status)))
    else $error("flag lost during clearing read");

    // reset leaves every flag at zero
    a_reset_zero: assert property (@(posedge ref_clk) disable iff (1'b0)
        sys_rst |=> (pre_reg_fault_status == 8'h00) && (pre_reg_thermal_status == 8'h00)
            && (lv_reg_fault_status == 8'h00) && !rd_valid && !cmd_err)
    else $error("flags not zero after reset");

    // a write attempt is refused and answers with no data
    a_write_refused: assert property (
        (cmd_valid && cmd_write) |=> (cmd_err && !rd_valid))
    else $error("write attempt not refused");

    // reserved bits never read as one
    a_reserved_zero: assert property (
        ((pre_reg_fault_status & ~`PRE_FAULT_MASK) == 8'h00)
        && ((pre_reg_thermal_status & ~`PRE_THERM_MASK) == 8'h00)
        && ((lv_reg_fault_status & ~`LV_FAULT_MASK) == 8'h00))
    else $error("reserved status bit set");

    // extreme overvoltage lands in bit five of the pre-regulator register
    a_extreme_ov_bit: assert property (
        pre_reg_extreme_ov_cond |=> pre_reg_fault_status[`PRE_FAULT_EXTREME_OV_BIT])
    else $error("extreme overvoltage flag missing");

    // the thermal read answers with the thermal register
    a_thermal_answer: assert property (
        rd_pre_therm |=> rd_valid && (rd_data == $past(pre_reg_thermal_status)))
    else $error("thermal read answer wrong");

    // low-voltage short to ground reaches the answer of the following read
    a_lv_short_read: assert property (
        lv_reg_short_gnd_cond ##1 rd_lv_fault
        |=> rd_valid && rd_data[`LV_FAULT_SHORT_GND_BIT])
    else $error("low-voltage short flag not reported");

    // confirm read after clear reports zero
    a_confirm_read: assert property (
        (rd_lv_fault && (lv_fault_cond == 8'h00)) ##1 (lv_fault_cond == 8'h00)
        ##1 rd_lv_fault |=> (rd_data == 8'h00))
    else $error("confirming read not zero");

    // ground loss lands in bit four of the pre-regulator register
    a_pre_gnd_bit: assert property (
        pre_reg_ground_loss_cond |=> pre_reg_fault_status[`PRE_FAULT_GROUND_LOSS_BIT])
    else $error("pre-regulator ground loss flag missing");

    // overvoltage protection lands in bit three
    a_pre_ovp_bit: assert property (
        pre_reg_ov_protect_cond |=> pre_reg_fault_status[`PRE_FAULT_OV_PROTECT_BIT])
    else $error("pre-regulator overvoltage flag missing");

    // sink current limit lands in bit two
    a_pre_sink_bit: assert property (
        pre_reg_sink_limit_cond |=> pre_reg_fault_status[`PRE_FAULT_SINK_LIMIT_BIT])
    else $error("pre-regulator sink limit flag missing");

    // overload lands in bit one
    a_pre_load_bit: assert property (
        pre_reg_overload_cond |=> pre_reg_fault_status[`PRE_FAULT_OVERLOAD_BIT])
    else $error("pre-regulator overload flag missing");

    // short to ground lands in bit zero
    a_pre_short_bit: assert property (
        pre_reg_short_gnd_cond |=> pre_reg_fault_status[`PRE_FAULT_SHORT_GND_BIT])
    else $error("pre-regulator short flag missing");

    // thermal shutdown lands in bit one of the thermal register
    a_shutdown_bit: assert property (
        pre_reg_thermal_shutdown_cond |=> pre_reg_thermal_status[`PRE_THERM_SHUTDOWN_BIT])
    else $error("thermal shutdown flag missing");

    // overtemperature warning lands in bit zero of the thermal register
    a_warning_bit: assert property (
        pre_reg_thermal_warning_cond |=> pre_reg_thermal_status[`PRE_THERM_WARNING_BIT])
    else $error("thermal warning flag missing");

    // low-voltage ground loss lands in bit four
    a_lv_gnd_bit: assert property (
        lv_reg_ground_loss_cond |=> lv_reg_fault_status[`LV_FAULT_GROUND_LOSS_BIT])
    else $error("low-voltage ground loss flag missing");

    // low-voltage overvoltage protection lands in bit three
    a_lv_ovp_bit: assert property (
        lv_reg_ov_protect_cond |=> lv_reg_fault_status[`LV_FAULT_OV_PROTECT_BIT])
    else $error("low-voltage overvoltage flag missing");

    // low-voltage sink current limit lands in bit two
    a_lv_sink_bit: assert property (
        lv_reg_sink_limit_cond |=> lv_reg_fault_status[`LV_FAULT_SINK_LIMIT_BIT])
    else $error("low-voltage sink limit flag missing");

    // low-voltage overload lands in bit one
    a_lv_load_bit: assert property (
        lv_reg_overload_cond |=> lv_reg_fault_status[`LV_FAULT_OVERLOAD_BIT])
    else $error("low-voltage overload flag missing");

    // low-voltage short to ground lands in bit zero
    a_lv_short_bit: assert property (
        lv_reg_short_gnd_cond |=> lv_reg_fault_status[`LV_FAULT_SHORT_GND_BIT])
    else $error("low-voltage short flag missing");

    // a pre-regulator read with no condition left empties the register
    a_pre_read_clears: assert property (
        (rd_pre_fault && (pre_fault_cond == 8'h00)) |=> (pre_reg_fault_status == 8'h00))
    else $error("pre-regulator flags survived a read with no condition");

    // same for the low-voltage register
    a_lv_read_clears: assert property (
        (rd_lv_fault && (lv_fault_cond == 8'h00)) |=> (lv_reg_fault_status == 8'h00))
    else $error("low-voltage flags survived a read with no condition");

    // a thermal condition still present during its read keeps the flag
    a_therm_keeps: assert property (
        (rd_pre_therm && (pre_therm_cond != 8'h00))
        |=> ((pre_reg_thermal_status & $past(pre_therm_cond)) == $past(pre_therm_cond)))
    else $error("thermal flag lost during clearing read");

    // the pre-regulator fault read answers with its own register
    a_pre_answer: assert property (
        rd_pre_fault |=> rd_valid && (rd_data == $past(pre_reg_fault_status)))
    else $error("pre-regulator read answer wrong");

    // same for the low-voltage read
    a_lv_answer: assert property (
        rd_lv_fault |=> rd_valid && (rd_data == $past(lv_reg_fault_status)))
    else $error("low-voltage read answer wrong");

    // codes outside the three reads are refused and leave the answer empty
    a_unknown_refused: assert property (
        (cmd_valid && !cmd_write && !(cmd_code inside {`CMD_READ_PRE_REG_FAULT,
            `CMD_READ_PRE_REG_THERMAL, `CMD_READ_LV_REG_FAULT}))
        |=> (cmd_err && !rd_valid && (rd_data == 8'h00)))
    else $error("unknown command not refused");

    // a write never clears a flag, since there is no write path
    a_write_keeps: assert property (
        (cmd_valid && cmd_write) |=> ((pre_reg_fault_status & $past(pre_reg_fault_status))
            == $past(pre_reg_fault_status)))
    else $error("write attempt changed a flag");

    // no command, no answer: the answer lines rest at zero
    a_idle_quiet: assert property (
        !cmd_valid |=> (!rd_valid && !cmd_err && (rd_data == 8'h00)))
    else $error("answer without a command");

    // the pending summary follows the flags
    a_pending_or: assert property (
        fault_pending == |{pre_reg_fault_status, pre_reg_thermal_status, lv_reg_fault_status})
    else $error("pending summary disagrees with flags");

    // main scenarios
    c_fault_read_clear: cover property (
        (pre_fault_cond != 8'h00) ##1 (pre_fault_cond == 8'h00) [*2] ##0 rd_pre_fault
        ##1 (pre_reg_fault_status == 8'h00));
    c_read_while_active: cover property (rd_lv_fault && (lv_fault_cond != 8'h00));
    c_write_refused: cover property (cmd_valid && cmd_write);
    c_thermal_shutdown: cover property (pre_reg_thermal_shutdown_cond ##1 rd_pre_therm);
    c_confirm_zero: cover property (rd_pre_therm ##1 rd_pre_therm ##1 (rd_data == 8'h00));

endmodule // regulator_fault_status_flags

//--- host_model.sv
// Purpose: host controller model issuing decoded register commands
// Assumes: called just after a clock edge; each command stands one cycle
// Notes: idle code lines carry the inverse of their previous value, so every second idle cycle shows the last command's code and write bit with cmd_valid low
`timescale 1ns/1ps
module host_model (
    // command lines toward the flag bank
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code
);
    // lines start idle before the first command
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
    end

    // one cycle of the port; idle lines toggle, so a stale value never stands two cycles in a row
    task automatic drive(input logic v, input logic w, input logic [7:0] c);
        cmd_valid = v;
        cmd_write = v ? w : ~cmd_write;
        cmd_code = v ? c : ~cmd_code;
    endtask
endmodule // host_model

//--- tb_top.sv
// Purpose: self-checking bench for the read-to-clear regulator flag bank
// Assumes: flags follow a reference updated at every edge from the rules
// Notes: answers are queued when a command is taken and popped when they appear
`timescale 1ns/1ps
`include "reg_flags_cfg.svh"
module tb_top;
    logic ref_clk, sys_rst, cmd_valid, cmd_write, rd_valid, cmd_err, fault_pending;
    logic [12:0] cond;
    logic [7:0] cmd_code, rd_data, k, ref_pre, ref_thm, ref_lv;
    logic [7:0] pre_reg_fault_status, pre_reg_thermal_status, lv_reg_fault_status;
    logic [2:0] hit;
    logic [8:0] got;
    logic [8:0] exp_q[$];
    logic [31:0] r;
    int n_errors, n_checks, n_cyc;

    // free-running 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    host_model i_host (.cmd_valid, .cmd_write, .cmd_code);

    regulator_fault_status_flags i_dut (.ref_clk, .sys_rst,
        .pre_reg_extreme_ov_cond(cond[5]), .pre_reg_ground_loss_cond(cond[4]),
        .pre_reg_ov_protect_cond(cond[3]), .pre_reg_sink_limit_cond(cond[2]),
        .pre_reg_overload_cond(cond[1]), .pre_reg_short_gnd_cond(cond[0]),
        .pre_reg_thermal_shutdown_cond(cond[7]), .pre_reg_thermal_warning_cond(cond[6]),
        .lv_reg_ground_loss_cond(cond[12]), .lv_reg_ov_protect_cond(cond[11]),
        .lv_reg_sink_limit_cond(cond[10]), .lv_reg_overload_cond(cond[9]),
        .lv_reg_short_gnd_cond(cond[8]), .cmd_valid, .cmd_write, .cmd_code,
        .rd_data, .rd_valid, .cmd_err, .pre_reg_fault_status, .pre_reg_thermal_status,
        .lv_reg_fault_status, .fault_pending);

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic results;
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic step(input logic [12:0] c, input logic v, input logic w, input logic [7:0] kc);
        @(posedge ref_clk);
        #1;
        cond = c;
        i_host.drive(v, w, kc);
    endtask

    // reference flags; read data is the value before the clearing edge
    always @(posedge ref_clk) begin
        n_cyc++;
        if (n_cyc > 20000) begin
            n_errors++;
            results();
        end else if (sys_rst) begin
            {ref_pre, ref_thm, ref_lv} = '0;
        end else begin
            hit = {3{cmd_valid & ~cmd_write}} & {cmd_code == `CMD_READ_PRE_REG_FAULT,
                cmd_code == `CMD_READ_PRE_REG_THERMAL, cmd_code == `CMD_READ_LV_REG_FAULT};
            if (cmd_valid && hit == 3'b000) exp_q.push_back(9'h100);
            if (hit[2]) exp_q.push_back({1'b0, ref_pre});
            if (hit[1]) exp_q.push_back({1'b0, ref_thm});
            if (hit[0]) exp_q.push_back({1'b0, ref_lv});
            ref_pre = {2'h0, cond[5:0]} | (hit[2] ? 8'h00 : ref_pre);
            ref_thm = {6'h00, cond[7:6]} | (hit[1] ? 8'h00 : ref_thm);
            ref_lv = {3'h0, cond[12:8]} | (hit[0] ? 8'h00 : ref_lv);
        end
    end

    // watcher: settled outputs after each edge against the oldest note
    always @(posedge ref_clk) begin
        #2;
        if (rd_valid === 1'b1 || cmd_err === 1'b1) begin
            got = exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF;
            check({cmd_err, rd_data} === got && rd_valid === !got[8], "read answer");
        end else begin
            check(rd_data === 8'h00, "idle read data");
        end
        check({pre_reg_fault_status, pre_reg_thermal_status, lv_reg_fault_status} ===
            {ref_pre, ref_thm, ref_lv}, "live flags");
        check(fault_pending === |{ref_pre, ref_thm, ref_lv}, "pending");
    end

    initial begin
        sys_rst = 1'b1;
        cond = '0;
        n_errors = 0;
        n_checks = 0;
        n_cyc = 0;
        r = $urandom(32'h6C78);
        repeat (20) step('0, 1'b0, 1'b0, 8'h00);
        sys_rst = 1'b0;
        // one flag at a time: latch, clear on read, confirm with second read
        for (int b = 0; b < 13; b++) begin
            k = b < 6 ? `CMD_READ_PRE_REG_FAULT : b < 8 ? `CMD_READ_PRE_REG_THERMAL
                : `CMD_READ_LV_REG_FAULT;
            step(13'h0001 << b, 1'b0, 1'b0, 8'h00);
            step('0, 1'b0, 1'b0, 8'h00);
            step('0, 1'b1, 1'b0, k);
            step('0, 1'b1, 1'b0, k);
        end
        step(13'h1FFF, 1'b1, 1'b0, `CMD_READ_PRE_REG_FAULT);
        step(13'h1FFF, 1'b1, 1'b0, `CMD_READ_PRE_REG_THERMAL);
        step('0, 1'b1, 1'b1, `CMD_READ_PRE_REG_FAULT);
        step('0, 1'b1, 1'b0, 8'h24);
        step('0, 1'b1, 1'b0, 8'h20);
        step('0, 1'b0, 1'b0, 8'h00);
        sys_rst = 1'b1;
        repeat (2) step(13'h1FFF, 1'b0, 1'b0, 8'h00);
        sys_rst = 1'b0;
        // random sparse faults under randomly spaced mixed commands
        repeat (3000) begin
            r = $urandom;
            step(r[12:0] & r[25:13], r[26], r[27] & r[28], {6'h08, r[30:29]});
        end
        repeat (3) step('0, 1'b0, 1'b0, 8'h00);
        check(exp_q.size() == 0, "answers missing");
        results();
    end
endmodule // tb_top
